// ===== mfp_out_pkg.sv
// constants and types for the multi-function pin output block
// assumes an 8-bit paged register port driven by the control interface
package mfp_out_pkg;

  // -------------------------------------------------------------
  // register map (page 0)
  // -------------------------------------------------------------
  localparam logic [7:0] REG_PAGE = 8'h00;
  localparam logic [7:0] BIDIR_CFG_ADDR = 8'h21;
  localparam logic [7:0] OUT_PIN1_CFG_ADDR = 8'h22;
  localparam logic [7:0] OUT_PIN2_CFG_ADDR = 8'h23;
  localparam logic [7:0] OUT_PIN3_CFG_ADDR = 8'h24;
  localparam logic [7:0] OUT_PIN4_CFG_ADDR = 8'h25;
  localparam logic [7:0] PIN_OUTPUT_LEVELS_ADDR = 8'h29;
  localparam logic [7:0] PIN_INPUT_MONITOR_ADDR = 8'h2a;

  // -------------------------------------------------------------
  // field layout
  // -------------------------------------------------------------
  localparam int NUM_PINS = 5;
  localparam int FUNC_LSB = 4;
  localparam int DRIVE_LSB = 0;
  localparam int LEVEL_TOP_BIT = 7;
  localparam int MON_BIT = 7;

  // -------------------------------------------------------------
  // function codes
  // -------------------------------------------------------------
  localparam logic [3:0] FUNC_DISABLED = 4'h0;
  localparam logic [3:0] FUNC_GEN_OUT = 4'h1;
  localparam logic [3:0] FUNC_IRQ_OUT = 4'h2;
  localparam logic [3:0] FUNC_SEC_SERIAL = 4'h3;
  localparam logic [3:0] FUNC_PDM_CLK = 4'h4;
  localparam logic [3:0] FUNC_GEN_IN = 4'h9;

  // -------------------------------------------------------------
  // drive style codes
  // -------------------------------------------------------------
  localparam logic [2:0] DRV_HIZ = 3'h0;
  localparam logic [2:0] DRV_PUSH_PULL = 3'h1;
  localparam logic [2:0] DRV_LOW_WEAKHI = 3'h2;
  localparam logic [2:0] DRV_LOW_HIZ = 3'h3;
  localparam logic [2:0] DRV_WEAKLO_HIGH = 3'h4;
  localparam logic [2:0] DRV_HIZ_HIGH = 3'h5;

  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [3:0] RST_BIDIR_FUNC = 4'h2;
  localparam logic [2:0] RST_BIDIR_DRIVE = 3'h2;
  localparam logic [3:0] RST_OUT_FUNC = 4'h0;
  localparam logic [2:0] RST_OUT_DRIVE = 3'h0;
  localparam logic [4:0] RST_LEVELS = 5'h00;

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef struct packed {
    logic [3:0] func;
    logic [2:0] drive;
  } pin_cfg_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] value;
    logic [NUM_PINS-1:0] strong_en;
    logic [NUM_PINS-1:0] weak_en;
  } pin_drive_t;

endpackage

// ===== pin_drive_ctrl.sv
// per-pin function mux and drive-style decoder, purely combinational
// assumes the caller registers the outputs before they reach the pad
`timescale 1ns/1ps
module pin_drive_ctrl
  import mfp_out_pkg::*;
(
  input wire logic [3:0] i_func, // selected pin function
  input wire logic [2:0] i_drive, // selected drive style
  input wire logic i_level, // software output level
  input wire logic i_irq, // internal interrupt source
  input wire logic i_sec_serial, // internal secondary serial data
  input wire logic i_pdm_clk, // internal pdm clock
  output logic o_value, // level toward the pad
  output logic o_strong_en, // active drive enable
  output logic o_weak_en // weak drive enable
);

  always_comb begin
    logic src;
    logic known;
    src = 1'b0;
    known = 1'b1;
    o_value = 1'b0;
    o_strong_en = 1'b0;
    o_weak_en = 1'b0;
    case (i_func)
      FUNC_GEN_OUT: src = i_level;
      FUNC_IRQ_OUT: src = i_irq;
      FUNC_SEC_SERIAL: src = i_sec_serial;
      FUNC_PDM_CLK: src = i_pdm_clk;
      default: known = 1'b0;
    endcase
    if (known) begin
      o_value = src;
      if (i_func == FUNC_SEC_SERIAL) begin
        o_strong_en = 1'b1;
      end else begin
        case (i_drive)
          DRV_PUSH_PULL: o_strong_en = 1'b1;
          DRV_LOW_WEAKHI: begin
            o_strong_en = ~src;
            o_weak_en = src;
          end
          DRV_LOW_HIZ: o_strong_en = ~src;
          DRV_WEAKLO_HIGH: begin
            o_strong_en = src;
            o_weak_en = ~src;
          end
          DRV_HIZ_HIGH: o_strong_en = src;
          default: o_strong_en = 1'b0;
        endcase
      end
    end
  end

endmodule // pin_drive_ctrl

// ===== mfp_out_top.sv
// multi-function pin configuration, output level and input monitor registers
// assumes page/address/strobes synchronous to i_ref_clk, one access per cycle
`timescale 1ns/1ps
module mfp_out_top
  import mfp_out_pkg::*;
(
  input wire logic i_ref_clk, // 40 MHz device clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [7:0] i_reg_page, // register page
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic i_irq, // internal interrupt source
  input wire logic i_sec_serial, // internal secondary serial data
  input wire logic i_pdm_clk, // internal pdm clock
  input wire logic i_bidir_pin_in, // bidirectional pin input level
  output logic [7:0] o_reg_rdata, // read data
  output logic o_reg_rvalid, // read data valid pulse
  output logic [NUM_PINS-1:0] o_pin_value, // pad level, bit 0 bidir
  output logic [NUM_PINS-1:0] o_pin_strong_en, // active drive enable
  output logic [NUM_PINS-1:0] o_pin_weak_en // weak drive enable
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    pin_cfg_t [NUM_PINS-1:0] cfg;
    logic [NUM_PINS-1:0] levels;
    logic mon;
    logic [7:0] rdata;
    logic rvalid;
    pin_drive_t drv;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  reg_req_t req;
  wire pin_drive_t drv_comb;

  assign req = '{page: i_reg_page, addr: i_reg_addr, wdata: i_reg_wdata,
                 wr: i_reg_wr, rd: i_reg_rd};

  // -------------------------------------------------------------
  // per-pin drive decode
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      pin_drive_ctrl pin_drive_ctrl_inst (
        .i_func(st_ff.cfg[g].func),
        .i_drive(st_ff.cfg[g].drive),
        .i_level(st_ff.levels[NUM_PINS-1-g]),
        .i_irq(i_irq),
        .i_sec_serial(i_sec_serial),
        .i_pdm_clk(i_pdm_clk),
        .o_value(drv_comb.value[g]),
        .o_strong_en(drv_comb.strong_en[g]),
        .o_weak_en(drv_comb.weak_en[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // register file and next state
  // -------------------------------------------------------------
  always_comb begin
    logic on_page;
    logic [7:0] cfg_lo;
    on_page = (req.page == REG_PAGE);
    cfg_lo = BIDIR_CFG_ADDR;
    nxt_st = st_ff;
    nxt_st.drv = drv_comb;
    nxt_st.rvalid = 1'b0;
    nxt_st.mon = (st_ff.cfg[0].func == FUNC_GEN_IN) ? i_bidir_pin_in : 1'b0;
    if (req.wr && on_page) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (req.addr == cfg_lo + 8'(i)) begin
          nxt_st.cfg[i].func = req.wdata[FUNC_LSB +: 4];
          nxt_st.cfg[i].drive = req.wdata[DRIVE_LSB +: 3];
        end
      end
      if (req.addr == PIN_OUTPUT_LEVELS_ADDR) begin
        nxt_st.levels = req.wdata[LEVEL_TOP_BIT -: NUM_PINS];
      end
    end
    if (req.rd) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = 8'h00;
      if (on_page) begin
        for (int i = 0; i < NUM_PINS; i++) begin
          if (req.addr == cfg_lo + 8'(i)) begin
            nxt_st.rdata = {st_ff.cfg[i].func, 1'b0, st_ff.cfg[i].drive};
          end
        end
        if (req.addr == PIN_OUTPUT_LEVELS_ADDR) begin
          nxt_st.rdata = {st_ff.levels, 3'h0};
        end
        if (req.addr == PIN_INPUT_MONITOR_ADDR) begin
          nxt_st.rdata = {st_ff.mon, 7'h00};
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
      st_ff.cfg[0].func <= RST_BIDIR_FUNC;
      st_ff.cfg[0].drive <= RST_BIDIR_DRIVE;
      for (int i = 1; i < NUM_PINS; i++) begin
        st_ff.cfg[i].func <= RST_OUT_FUNC;
        st_ff.cfg[i].drive <= RST_OUT_DRIVE;
      end
      st_ff.levels <= RST_LEVELS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata = st_ff.rdata;
  assign o_reg_rvalid = st_ff.rvalid;
  assign o_pin_value = st_ff.drv.value;
  assign o_pin_strong_en = st_ff.drv.strong_en;
  assign o_pin_weak_en = st_ff.drv.weak_en;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_pin3_gen_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[3].func == FUNC_GEN_OUT && st_ff.cfg[3].drive == DRV_PUSH_PULL)
      |=> o_pin_strong_en[3] && (o_pin_value[3] == $past(st_ff.levels[1]));
  endproperty
  a_pin3_gen_out: assert property (p_pin3_gen_out) else $error("pin3 level wrong");

  property p_pin4_pdm;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[4].func == FUNC_PDM_CLK) |=> (o_pin_value[4] == $past(i_pdm_clk));
  endproperty
  a_pin4_pdm: assert property (p_pin4_pdm) else $error("pin4 pdm clock wrong");

  property p_weak_high;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[3].func == FUNC_GEN_OUT && st_ff.cfg[3].drive == DRV_LOW_WEAKHI
      && st_ff.levels[1]) |=> o_pin_weak_en[3] && !o_pin_strong_en[3];
  endproperty
  a_weak_high: assert property (p_weak_high) else $error("weak high style wrong");

  property p_serial_ignores_drive;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[4].func == FUNC_SEC_SERIAL) |=>
      o_pin_strong_en[4] && !o_pin_weak_en[4] && (o_pin_value[4] == $past(i_sec_serial));
  endproperty
  a_serial_ignores_drive: assert property (p_serial_ignores_drive) else $error("serial drive");

  property p_cfg_readback;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (req.wr && !req.rd && req.page == REG_PAGE && req.addr == OUT_PIN4_CFG_ADDR)
      ##1 !req.wr
      ##1 (req.rd && req.page == REG_PAGE && req.addr == OUT_PIN4_CFG_ADDR)
      |=> o_reg_rvalid && (o_reg_rdata == ($past(i_reg_wdata, 3) & 8'hf7));
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("cfg readback wrong");

  property p_bidir_gen_out;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[0].func == FUNC_GEN_OUT && st_ff.cfg[0].drive == DRV_PUSH_PULL)
      |=> o_pin_strong_en[0] && (o_pin_value[0] == $past(st_ff.levels[4]));
  endproperty
  a_bidir_gen_out: assert property (p_bidir_gen_out) else $error("bidir level wrong");

  property p_levels_read;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (req.rd && req.page == REG_PAGE && req.addr == PIN_OUTPUT_LEVELS_ADDR)
      |=> o_reg_rdata[2:0] == 3'h0 && o_reg_rdata[7:3] == $past(st_ff.levels);
  endproperty
  a_levels_read: assert property (p_levels_read) else $error("levels read wrong");

  property p_monitor;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[0].func == FUNC_GEN_IN && $stable(st_ff.cfg[0].func)) ##0
      (req.rd && req.page == REG_PAGE && req.addr == PIN_INPUT_MONITOR_ADDR)
      |=> o_reg_rdata == {$past(i_bidir_pin_in, 2), 7'h00};
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor value wrong");

  property p_reserved_undriven;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[4].func > FUNC_PDM_CLK || (st_ff.cfg[4].drive > DRV_HIZ_HIGH
      && st_ff.cfg[4].func != FUNC_SEC_SERIAL)) |=> !o_pin_strong_en[4] && !o_pin_weak_en[4];
  endproperty
  a_reserved_undriven: assert property (p_reserved_undriven) else $error("reserved drives");

  property p_irq_source;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_ff.cfg[4].func == FUNC_IRQ_OUT) |=> (o_pin_value[4] == $past(i_irq));
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("irq source wrong");

  c_levels_write: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    req.wr && req.addr == PIN_OUTPUT_LEVELS_ADDR);
  c_serial_mode: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.cfg[4].func == FUNC_SEC_SERIAL);
  c_bidir_input: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_ff.cfg[0].func == FUNC_GEN_IN ##1 st_ff.mon);

endmodule // mfp_out_top

// ===== mfp_board_model.sv
// board-side model of the pads behind the multi-function pins
// assumes drive enables from the block; undriven pads pulled up on the board
`timescale 1ns/1ps
module mfp_board_model
  import mfp_out_pkg::*;
(
  input wire logic [NUM_PINS-1:0] i_value, // level from the block
  input wire logic [NUM_PINS-1:0] i_strong_en, // active drive from the block
  input wire logic [NUM_PINS-1:0] i_weak_en, // weak drive from the block
  input wire logic i_ext_drive, // board drives the bidir pad
  input wire logic i_ext_level, // level the board drives
  output logic [NUM_PINS-1:0] o_pad, // resolved pad levels
  output logic o_bidir_in // bidir pad level back to the block
);
  // ---------------------------------------------------------------
  // pad resolution: strong, then board, then weak, then pull-up
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (i_strong_en[i]) begin
        o_pad[i] = i_value[i];
      end else if (i == 0 && i_ext_drive) begin
        o_pad[i] = i_ext_level;
      end else if (i_weak_en[i]) begin
        o_pad[i] = i_value[i];
      end else begin
        o_pad[i] = 1'b1;
      end
    end
  end
  assign o_bidir_in = o_pad[0];
endmodule // mfp_board_model

// ===== mfp_out_top_tb.sv
// self-checking bench for the multi-function pin output block
// assumes the board model resolves pads; registers reached by strobes
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mfp_out_top_tb;
  import mfp_out_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq = 0, ser = 0, pdm = 0;
  logic ext_drv = 0, ext_lvl = 0, rvalid, bidir_in;
  logic [7:0] page = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
  logic [NUM_PINS-1:0] pv, ps, pw, pad;
  int err_total = 0, compares = 0, cyc = 0;

  mfp_out_top mfp_out_top_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_reg_page(page),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .i_irq(irq),
    .i_sec_serial(ser), .i_pdm_clk(pdm), .i_bidir_pin_in(bidir_in), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_pin_value(pv), .o_pin_strong_en(ps), .o_pin_weak_en(pw));
  mfp_board_model mfp_board_model_inst (.i_value(pv), .i_strong_en(ps), .i_weak_en(pw),
    .i_ext_drive(ext_drv), .i_ext_level(ext_lvl), .o_pad(pad), .o_bidir_in(bidir_in));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus and pin helpers
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a; wdata = d; wr = 1'b1;
    @(posedge clk); #2 wr = 1'b0;
    @(posedge clk); #2;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a; rd = 1'b1;
    @(posedge clk); #2 rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
    @(posedge clk); #2;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #2;
  endtask

  task automatic chk_pin(input int i, input logic v, input logic s, input logic w);
    `CHK(ps[i], s)
    `CHK(pw[i], w)
    `CHK(pad[i], (s | w) ? v : 1'b1)
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    rd_reg(OUT_PIN3_CFG_ADDR, d); `CHK(d, 8'h00)
    rd_reg(OUT_PIN4_CFG_ADDR, d); `CHK(d, 8'h00)
    rd_reg(PIN_OUTPUT_LEVELS_ADDR, d); `CHK(d, 8'h00)
    rd_reg(PIN_INPUT_MONITOR_ADDR, d); `CHK(d, 8'h00)
    chk_pin(3, 1'b0, 1'b0, 1'b0);
    chk_pin(4, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_layout();
    logic [7:0] d;
    wr_reg(OUT_PIN3_CFG_ADDR, 8'hff); settle();
    rd_reg(OUT_PIN3_CFG_ADDR, d); `CHK(d, 8'hf7)
    chk_pin(3, 1'b0, 1'b0, 1'b0);
    wr_reg(OUT_PIN4_CFG_ADDR, 8'h1f);
    rd_reg(OUT_PIN4_CFG_ADDR, d); `CHK(d, 8'h17)
    chk_pin(4, 1'b0, 1'b0, 1'b0);
    wr_reg(PIN_OUTPUT_LEVELS_ADDR, 8'hff);
    rd_reg(PIN_OUTPUT_LEVELS_ADDR, d); `CHK(d, 8'hf8)
    page = 8'h01; wr_reg(OUT_PIN3_CFG_ADDR, 8'h00); page = 8'h00;
    rd_reg(OUT_PIN3_CFG_ADDR, d); `CHK(d, 8'hf7)
    rd_reg(8'h30, d); `CHK(d, 8'h00)
  endtask

  task automatic t_drive();
    logic s, w;
    for (int d = 0; d < 8; d++) begin
      wr_reg(OUT_PIN3_CFG_ADDR, {FUNC_GEN_OUT, 1'b0, 3'(d)});
      for (int l = 0; l < 2; l++) begin
        wr_reg(PIN_OUTPUT_LEVELS_ADDR, {3'h0, 1'(l), 4'h0}); settle();
        s = (d == 1) || (l == 0 && (d == 2 || d == 3)) || (l == 1 && (d == 4 || d == 5));
        w = (l == 1 && d == 2) || (l == 0 && d == 4);
        chk_pin(3, 1'(l), s, w);
      end
    end
  endtask

  task automatic t_func();
    logic v;
    wr_reg(PIN_OUTPUT_LEVELS_ADDR, 8'h08);
    for (int f = 0; f < 6; f++) begin
      wr_reg(OUT_PIN4_CFG_ADDR, {4'(f), 1'b0, (f == 3) ? 3'h0 : 3'h1});
      for (int s = 0; s < 4; s++) begin
        irq = s[0]; ser = s[1]; pdm = s[0] ^ s[1];
        settle();
        v = (f == 1) ? 1'b1 : (f == 2) ? irq : (f == 3) ? ser : pdm;
        chk_pin(4, v, f >= 1 && f <= 4, 1'b0);
      end
    end
  endtask

  task automatic t_pins12();
    wr_reg(OUT_PIN1_CFG_ADDR, 8'h11);
    wr_reg(OUT_PIN2_CFG_ADDR, 8'h11);
    wr_reg(PIN_OUTPUT_LEVELS_ADDR, 8'h40); settle();
    chk_pin(1, 1'b1, 1'b1, 1'b0);
    chk_pin(2, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic t_bidir();
    logic [7:0] d;
    wr_reg(BIDIR_CFG_ADDR, 8'h11);
    wr_reg(PIN_OUTPUT_LEVELS_ADDR, 8'h80); settle();
    chk_pin(0, 1'b1, 1'b1, 1'b0);
    ext_drv = 1'b1; ext_lvl = 1'b1;
    wr_reg(BIDIR_CFG_ADDR, 8'h90); settle();
    `CHK(ps[0] | pw[0], 1'b0)
    rd_reg(PIN_INPUT_MONITOR_ADDR, d); `CHK(d, 8'h80)
    ext_lvl = 1'b0; settle();
    rd_reg(PIN_INPUT_MONITOR_ADDR, d); `CHK(d, 8'h00)
    ext_lvl = 1'b1; wr_reg(PIN_INPUT_MONITOR_ADDR, 8'h00); settle();
    rd_reg(PIN_INPUT_MONITOR_ADDR, d); `CHK(d, 8'h80)
    ext_drv = 1'b0;
    wr_reg(BIDIR_CFG_ADDR, 8'h11); settle();
    rd_reg(PIN_INPUT_MONITOR_ADDR, d); `CHK(d, 8'h00)
  endtask

  // ---------------------------------------------------------------
  // verdict, timeout and main sequence
  // ---------------------------------------------------------------
  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    t_reset();
    t_layout();
    t_drive();
    t_func();
    t_pins12();
    t_bidir();
    summarize();
  end
endmodule // mfp_out_top_tb
